// file: include/mrd_pkg.sv
/*
 * constants and types shared by the mirror reset driver control port:
 * register offsets, field positions, reset values, pin vector layout and
 * serial engine states.
 * assumes the register bus carries byte addresses of 8 bits, 32-bit data.
 */
`default_nettype none
package mrd_pkg;
	// register bus
	localparam int BUS_AW = 8;
	localparam int BUS_DW = 32;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_LATCH = 8'h04;
	localparam logic [7:0] OFF_PINS = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_MASK = 8'h10;
	localparam logic [7:0] OFF_SDATA = 8'h14;
	localparam logic [7:0] OFF_CCNT = 8'h18;
	// control register: regulator enables
	localparam int CTRL_W = 3;
	localparam int CTRL_BIAS = 0;
	localparam int CTRL_OFFS = 1;
	localparam int CTRL_NEG = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	// interrupt status and mask layout
	localparam int IRQ_W = 5;
	localparam int IRQ_STROBE = 0;
	localparam int IRQ_INIT = 1;
	localparam int IRQ_SWR = 2;
	localparam int IRQ_ABORT = 3;
	localparam int IRQ_OE = 4;
	localparam logic [4:0] STAT_RST = 5'h00;
	localparam logic [4:0] MASK_RST = 5'h00;
	// latched command fields
	localparam int BLK_W = 4;
	localparam int MODE_W = 2;
	localparam int LVL_W = 2;
	localparam int LAT_BLK = 0;
	localparam int LAT_MODE = 4;
	localparam int LAT_LVL = 6;
	localparam logic [1:0] LVL_OFFSET = 2'h0;
	localparam int CCNT_W = 16;
	// pin level register
	localparam int PIN_OE = 0;
	localparam int PIN_INIT = 1;
	localparam int PIN_SEL = 2;
	// synchronised pin vector
	localparam int PV_BLK = 0;
	localparam int PV_MODE = 4;
	localparam int PV_LVL = 6;
	localparam int PV_STRB = 8;
	localparam int PV_INIT = 9;
	localparam int PV_OE = 10;
	localparam int PV_SCLK = 11;
	localparam int PV_SEL = 12;
	localparam int PV_DIN = 13;
	localparam int PV_W = 14;
	localparam logic [13:0] PV_RST = 14'h0400;
	// serial frame: command byte then data byte, msb first
	localparam int SER_AW = 6;
	localparam int SER_RD = 7;
	localparam int SER_RSV = 6;
	localparam logic [2:0] SER_LAST = 3'h7;
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_CMD = 2'b01,
		SER_DATA = 2'b10,
		SER_DONE = 2'b11
	} mrd_ser_state_t;
endpackage
`default_nettype wire

// file: include/mrd_scp_if.sv
/*
 * link between the serial engine and the register core.
 * assumes both ends run on clk_sys; pin levels arrive already filtered.
 */
`timescale 1ns/1ps
`default_nettype none
interface mrd_scp_if;
	logic sclk;
	logic sel_n;
	logic din;
	logic dout;
	logic wr;
	logic rd;
	logic abort;
	logic rsv;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport engine (
		input sclk, sel_n, din, rdata,
		output dout, wr, rd, abort, rsv, addr, wdata
	);
	modport core (
		output sclk, sel_n, din, rdata,
		input dout, wr, rd, abort, rsv, addr, wdata
	);
endinterface
`default_nettype wire

// file: src/mrd_serial.sv
/*
 * serial communications port engine: command byte (read flag, reserved,
 * six-bit register index) then one data byte, msb first.
 * assumes filtered pin levels; serial clock much slower than clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module mrd_serial (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register core
	mrd_scp_if.engine scp
);
	typedef struct packed {
		mrd_pkg::mrd_ser_state_t st;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic [7:0] cmd;
		logic [7:0] tx;
		logic sclk_prev;
		logic load;
		logic dout;
		logic wr;
		logic rd;
		logic abort;
	} mrd_ser_reg_t;
	mrd_ser_reg_t q;
	mrd_ser_reg_t d;
	logic rise;
	logic fall;
	logic [7:0] sh_in;

	always_comb begin
		d = q;
		d.wr = 1'b0;
		d.rd = 1'b0;
		d.abort = 1'b0;
		d.load = q.rd;
		d.sclk_prev = scp.sclk;
		rise = scp.sclk & ~q.sclk_prev;
		fall = ~scp.sclk & q.sclk_prev;
		sh_in = {q.sh[6:0], scp.din};
		if (scp.sel_n) begin
			// deselect mid frame drops it and is reported
			if ((q.st == mrd_pkg::SER_CMD && q.cnt != 3'h0) ||
			    q.st == mrd_pkg::SER_DATA) begin
				d.abort = 1'b1;
			end
			d.st = mrd_pkg::SER_IDLE;
			d.cnt = 3'h0;
			d.dout = 1'b0;
		end else begin
			case (q.st)
			mrd_pkg::SER_IDLE: begin
				d.st = mrd_pkg::SER_CMD;
				d.cnt = 3'h0;
			end
			mrd_pkg::SER_CMD: begin
				if (rise) begin
					d.sh = sh_in;
					d.cnt = q.cnt + 3'h1;
					if (q.cnt == mrd_pkg::SER_LAST) begin
						d.cmd = sh_in;
						d.rd = sh_in[mrd_pkg::SER_RD];
						d.st = mrd_pkg::SER_DATA;
					end
				end
			end
			mrd_pkg::SER_DATA: begin
				if (fall) begin
					d.dout = q.tx[7];
					d.tx = {q.tx[6:0], 1'b0};
				end
				if (rise) begin
					d.sh = sh_in;
					d.cnt = q.cnt + 3'h1;
					if (q.cnt == mrd_pkg::SER_LAST) begin
						d.wr = ~q.cmd[mrd_pkg::SER_RD];
						d.st = mrd_pkg::SER_DONE;
					end
				end
			end
			mrd_pkg::SER_DONE: begin
				if (fall) begin
					d.dout = 1'b0;
				end
			end
			default: begin
				d.st = mrd_pkg::SER_IDLE;
			end
			endcase
		end
		// read word arrives two cycles after the command byte, long
		// before the first falling edge at any legal serial clock rate
		if (q.load) begin
			d.tx = scp.rdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign scp.dout = q.dout;
	assign scp.wr = q.wr;
	assign scp.rd = q.rd;
	assign scp.abort = q.abort;
	assign scp.rsv = q.cmd[mrd_pkg::SER_RSV];
	assign scp.addr = q.cmd[mrd_pkg::SER_AW-1:0];
	assign scp.wdata = q.sh;
endmodule
`default_nettype wire

// file: src/mrd_sync.sv
/*
 * three-stage pin synchroniser with agreement filter.
 * assumes pins are asynchronous to clk_sys; the reset value stands in for
 * the pull on each pin.
 */
`timescale 1ns/1ps
`default_nettype none
module mrd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// pins in, filtered levels out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} mrd_sync_reg_t;
	mrd_sync_reg_t q;
	mrd_sync_reg_t d;

	always_comb begin
		d = q;
		d.s1 = din;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// a bit changes only once stages two and three agree
		d.lvl = (q.s2 ~^ q.s3) & q.s3 | (q.s2 ^ q.s3) & q.lvl;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			q <= {RST, RST, RST, RST};
		end else begin
			q <= d;
		end
	end

	assign dout = q.lvl;
endmodule
`default_nettype wire

// file: src/mrd_top.sv
/*
 * control side of a micromirror reset driver: latches block, mode and
 * level selects on the strobe, gates the driver outputs, forces the
 * offset level during initialise, runs the serial port, drives the
 * regulator enables and the interrupt.
 * assumes all pins are asynchronous to clk_sys and that pin pulls are
 * outside; a register port on clk_sys.
 */
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mrd_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	// control pins from the display controller
	input wire logic [3:0] driver_block_sel,
	input wire logic [1:0] driver_mode_sel,
	input wire logic [1:0] driver_level_sel,
	input wire logic driver_strobe,
	input wire logic driver_output_enable_n,
	input wire logic driver_initialise_n,
	// serial communications port
	input wire logic serial_port_clock,
	input wire logic serial_port_select_n,
	input wire logic serial_port_data_in,
	output logic serial_port_data_out,
	// regulator enables and interrupt
	output logic bias_level_en,
	output logic offset_level_en,
	output logic negative_level_en,
	output logic driver_interrupt_n,
	// internal reset driver
	output logic [3:0] drv_block,
	output logic [1:0] drv_mode,
	output logic [1:0] drv_level,
	output logic drv_enable,
	output logic drv_offset_force
);
	typedef struct packed {
		logic [mrd_pkg::CTRL_W-1:0] ctrl;
		logic [mrd_pkg::IRQ_W-1:0] stat;
		logic [mrd_pkg::IRQ_W-1:0] mask;
		logic [mrd_pkg::BLK_W-1:0] blk;
		logic [mrd_pkg::MODE_W-1:0] mode;
		logic [mrd_pkg::LVL_W-1:0] lvl;
		logic [mrd_pkg::LVL_W-1:0] drv_lvl;
		logic [mrd_pkg::CCNT_W-1:0] ccnt;
		logic [7:0] sdata;
		logic [7:0] srdata;
		logic [31:0] rdata;
		logic strb_prev;
		logic init_prev;
		logic oe_prev;
		logic irq;
		logic drv_en;
		logic drv_force;
	} mrd_top_reg_t;

	localparam mrd_top_reg_t TOP_RST = '{
		ctrl: mrd_pkg::CTRL_RST,
		stat: mrd_pkg::STAT_RST,
		mask: mrd_pkg::MASK_RST,
		blk: '0,
		mode: '0,
		lvl: '0,
		drv_lvl: mrd_pkg::LVL_OFFSET,
		ccnt: '0,
		sdata: 8'h00,
		srdata: 8'h00,
		rdata: 32'h0000_0000,
		strb_prev: 1'b0,
		init_prev: 1'b0,
		oe_prev: 1'b1,
		irq: 1'b0,
		drv_en: 1'b0,
		drv_force: 1'b1
	};

	mrd_top_reg_t q;
	mrd_top_reg_t d;
	logic [mrd_pkg::PV_W-1:0] pin_raw;
	logic [mrd_pkg::PV_W-1:0] pv;
	logic [mrd_pkg::IRQ_W-1:0] set;
	logic [31:0] srd_word;
	logic strb_rise;

	mrd_scp_if scp ();

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	assign pin_raw[mrd_pkg::PV_BLK +: mrd_pkg::BLK_W] = driver_block_sel;
	assign pin_raw[mrd_pkg::PV_MODE +: mrd_pkg::MODE_W] = driver_mode_sel;
	assign pin_raw[mrd_pkg::PV_LVL +: mrd_pkg::LVL_W] = driver_level_sel;
	assign pin_raw[mrd_pkg::PV_STRB] = driver_strobe;
	assign pin_raw[mrd_pkg::PV_INIT] = driver_initialise_n;
	assign pin_raw[mrd_pkg::PV_OE] = driver_output_enable_n;
	assign pin_raw[mrd_pkg::PV_SCLK] = serial_port_clock;
	assign pin_raw[mrd_pkg::PV_SEL] = serial_port_select_n;
	assign pin_raw[mrd_pkg::PV_DIN] = serial_port_data_in;

	// reset levels mirror the pulls: all low but output enable high
	mrd_sync #(
		.W(mrd_pkg::PV_W),
		.RST(mrd_pkg::PV_RST)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.din(pin_raw),
		.dout(pv)
	);

	////////////////////////////////////////////////////////////////////////
	// serial engine

	assign scp.sclk = pv[mrd_pkg::PV_SCLK];
	assign scp.sel_n = pv[mrd_pkg::PV_SEL];
	assign scp.din = pv[mrd_pkg::PV_DIN];
	assign scp.rdata = q.srdata;

	mrd_serial u_serial (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.scp(scp)
	);

	////////////////////////////////////////////////////////////////////////
	// register access helpers

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
		mrd_pkg::OFF_CTRL: begin
			r[mrd_pkg::CTRL_W-1:0] = q.ctrl;
		end
		mrd_pkg::OFF_LATCH: begin
			r[mrd_pkg::LAT_BLK +: mrd_pkg::BLK_W] = q.blk;
			r[mrd_pkg::LAT_MODE +: mrd_pkg::MODE_W] = q.mode;
			r[mrd_pkg::LAT_LVL +: mrd_pkg::LVL_W] = q.lvl;
		end
		mrd_pkg::OFF_PINS: begin
			r[mrd_pkg::PIN_OE] = pv[mrd_pkg::PV_OE];
			r[mrd_pkg::PIN_INIT] = pv[mrd_pkg::PV_INIT];
			r[mrd_pkg::PIN_SEL] = pv[mrd_pkg::PV_SEL];
		end
		mrd_pkg::OFF_STAT: begin
			r[mrd_pkg::IRQ_W-1:0] = q.stat;
		end
		mrd_pkg::OFF_MASK: begin
			r[mrd_pkg::IRQ_W-1:0] = q.mask;
		end
		mrd_pkg::OFF_SDATA: begin
			r[7:0] = q.sdata;
		end
		mrd_pkg::OFF_CCNT: begin
			r[mrd_pkg::CCNT_W-1:0] = q.ccnt;
		end
		default: begin
			r = 32'h0000_0000;
		end
		endcase
		return r;
	endfunction

	function automatic mrd_top_reg_t wr_apply(input mrd_top_reg_t s,
			input logic [7:0] a, input logic [31:0] w);
		mrd_top_reg_t r;
		r = s;
		case (a)
		mrd_pkg::OFF_CTRL: begin
			r.ctrl = w[mrd_pkg::CTRL_W-1:0];
		end
		mrd_pkg::OFF_STAT: begin
			r.stat = s.stat & ~w[mrd_pkg::IRQ_W-1:0];
		end
		mrd_pkg::OFF_MASK: begin
			r.mask = w[mrd_pkg::IRQ_W-1:0];
		end
		default: begin
			r = s;
		end
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		d = q;
		set = '0;
		srd_word = rd_mux({scp.addr, 2'b00});
		d.strb_prev = pv[mrd_pkg::PV_STRB];
		d.init_prev = pv[mrd_pkg::PV_INIT];
		d.oe_prev = pv[mrd_pkg::PV_OE];
		// selects share the strobe's synchroniser delay, so a setup
		// before the pin edge is still a setup here
		strb_rise = pv[mrd_pkg::PV_STRB] & ~q.strb_prev;
		if (strb_rise) begin
			d.blk = pv[mrd_pkg::PV_BLK +: mrd_pkg::BLK_W];
			d.mode = pv[mrd_pkg::PV_MODE +: mrd_pkg::MODE_W];
			d.lvl = pv[mrd_pkg::PV_LVL +: mrd_pkg::LVL_W];
			d.ccnt = q.ccnt + 16'h0001;
		end
		set[mrd_pkg::IRQ_STROBE] = strb_rise;
		set[mrd_pkg::IRQ_INIT] = ~pv[mrd_pkg::PV_INIT] & q.init_prev;
		set[mrd_pkg::IRQ_SWR] = scp.wr & ~scp.rsv;
		set[mrd_pkg::IRQ_ABORT] = scp.abort;
		set[mrd_pkg::IRQ_OE] = pv[mrd_pkg::PV_OE] ^ q.oe_prev;
		// serial write first, so a bus write in the same cycle wins
		if (scp.wr && !scp.rsv) begin
			d = wr_apply(d, {scp.addr, 2'b00}, 32'(scp.wdata));
			d.sdata = scp.wdata;
		end
		if (bus_wr) begin
			d = wr_apply(d, bus_addr, bus_wdata);
		end
		// an event in the clearing cycle stays set
		d.stat = d.stat | set;
		d.irq = |(d.stat & d.mask);
		d.rdata = bus_rd ? rd_mux(bus_addr) : 32'h0000_0000;
		if (scp.rd) begin
			d.srdata = scp.rsv ? 8'h00 : srd_word[7:0];
		end
		d.drv_en = ~pv[mrd_pkg::PV_OE];
		d.drv_force = ~pv[mrd_pkg::PV_INIT];
		d.drv_lvl = d.drv_force ? mrd_pkg::LVL_OFFSET : d.lvl;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			q <= TOP_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign bus_rdata = q.rdata;
	assign serial_port_data_out = scp.dout;
	assign bias_level_en = q.ctrl[mrd_pkg::CTRL_BIAS];
	assign offset_level_en = q.ctrl[mrd_pkg::CTRL_OFFS];
	assign negative_level_en = q.ctrl[mrd_pkg::CTRL_NEG];
	assign driver_interrupt_n = ~q.irq;
	assign drv_block = q.blk;
	assign drv_mode = q.mode;
	assign drv_level = q.drv_lvl;
	assign drv_enable = q.drv_en;
	assign drv_offset_force = q.drv_force;
endmodule
`default_nettype wire

// file: test/mrd_ctrl_model.sv
/* display controller model for the serial port.
 assumes a 320 ns serial clock, eight clk_sys cycles. */
`timescale 1ns/1ps
`default_nettype none
module mrd_ctrl_model (
	// clock
	input wire logic clk_sys,
	// serial pins
	output logic sclk,
	output logic sel_n,
	output logic din,
	input wire logic dout
);
	initial begin
		sclk = 1'b0;
		sel_n = 1'b1;
		din = 1'b0;
	end
	// clock stands low outside frames; en low toggles with select high
	task automatic frame(input logic [7:0] cmd, input logic [7:0] dat,
		input int nbits, input logic en, output logic [7:0] rd);
		logic [15:0] sh;
		sh = {cmd, dat};
		rd = 8'h00;
		@(posedge clk_sys) sel_n <= !en;
		repeat (8) @(posedge clk_sys);
		for (int i = 0; i < nbits; i++) begin
			din <= sh[15 - i]; // moves with the falling clock
			repeat (4) @(posedge clk_sys);
			sclk <= 1'b1;
			repeat (3) @(posedge clk_sys);
			// sampled late: the pin filter delays data out by five cycles
			@(negedge clk_sys) rd = {rd[6:0], dout};
			@(posedge clk_sys) sclk <= 1'b0;
		end
		repeat (8) @(posedge clk_sys);
		din <= 1'b0; // released line falls to its pull-down
		sel_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// file: test/mrd_top_checker.sv
/* pin-level assertions for mrd_top.
 assumes every pin is held several clk_sys cycles between changes. */
`timescale 1ns/1ps
`default_nettype none
module mrd_top_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_rdata,
	// controller pins
	input wire logic [3:0] driver_block_sel,
	input wire logic [1:0] driver_mode_sel,
	input wire logic [1:0] driver_level_sel,
	input wire logic driver_strobe,
	input wire logic driver_output_enable_n,
	input wire logic driver_initialise_n,
	input wire logic serial_port_select_n,
	input wire logic serial_port_data_out,
	// outputs
	input wire logic bias_level_en,
	input wire logic offset_level_en,
	input wire logic negative_level_en,
	input wire logic driver_interrupt_n,
	input wire logic [3:0] drv_block,
	input wire logic [1:0] drv_mode,
	input wire logic [1:0] drv_level,
	input wire logic drv_enable,
	input wire logic drv_offset_force
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	////////////////////////////////
	// eight cycles covers the four-edge pin filter and the latch register with margin
	sequence s_cap;
		$rose(driver_strobe) ##0 (driver_strobe && $stable({driver_block_sel,
			driver_mode_sel, driver_level_sel}))[*8];
	endsequence
	property p_cap;
		s_cap |-> drv_block == driver_block_sel && drv_mode == driver_mode_sel;
	endproperty
	property p_hold;
		(!driver_strobe)[*8] |-> $stable(drv_block) && $stable(drv_mode);
	endproperty
	property p_oe;
		$stable(driver_output_enable_n)[*8] |->
			drv_enable == !driver_output_enable_n;
	endproperty
	property p_init;
		$stable(driver_initialise_n)[*8] |->
			drv_offset_force == !driver_initialise_n;
	endproperty
	property p_lvl;
		(!driver_initialise_n)[*8] |-> drv_level == mrd_pkg::LVL_OFFSET;
	endproperty
	property p_en;
		bus_wr && bus_addr == mrd_pkg::OFF_CTRL |=> {negative_level_en,
			offset_level_en, bias_level_en} == $past(bus_wdata[2:0]);
	endproperty
	property p_irq;
		bus_wr && bus_addr == mrd_pkg::OFF_MASK && bus_wdata[4:0] == 5'h00
			|=> ##1 driver_interrupt_n;
	endproperty
	property p_rdq;
		!$past(bus_rd) |-> bus_rdata == 32'h00000000;
	endproperty
	property p_sdo;
		serial_port_select_n[*8] |-> !serial_port_data_out;
	endproperty
	////////////////////////////////
	a_cap: assert property (p_cap)
		else $error("latched selects differ from pins");
	a_hold: assert property (p_hold)
		else $error("latched selects moved without strobe");
	a_oe: assert property (p_oe)
		else $error("driver enable does not follow enable pin");
	a_init: assert property (p_init)
		else $error("offset force does not follow initialise");
	a_lvl: assert property (p_lvl)
		else $error("level not forced to offset");
	a_en: assert property (p_en)
		else $error("regulator enables differ from write");
	a_irq: assert property (p_irq)
		else $error("interrupt low with mask clear");
	a_rdq: assert property (p_rdq)
		else $error("read data outside its cycle");
	a_sdo: assert property (p_sdo)
		else $error("serial out driven while deselected");
endmodule
bind mrd_top mrd_top_checker chk_u (.*);
`default_nettype wire

// file: test/testbench.sv
/* self-checking bench for mrd_top.
 assumes mrd_ctrl_model drives the serial pins. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [3:0] driver_block_sel = 4'h0;
	logic [1:0] driver_mode_sel = 2'h0;
	logic [1:0] driver_level_sel = 2'h0;
	logic driver_strobe = 1'b0;
	logic driver_output_enable_n = 1'b1;
	logic driver_initialise_n = 1'b0;
	logic [31:0] bus_rdata;
	logic serial_port_clock, serial_port_select_n, serial_port_data_in;
	logic serial_port_data_out, driver_interrupt_n;
	logic bias_level_en, offset_level_en, negative_level_en;
	logic [3:0] drv_block;
	logic [1:0] drv_mode, drv_level;
	logic drv_enable, drv_offset_force;
	logic rd_seen = 1'b0;
	logic [31:0] exp_q[$];
	logic [7:0] r = 8'h5e;
	logic [7:0] lat, rb;
	int bad_count = 0;
	int n_compared = 0;
	wire logic [2:0] ens = {negative_level_en, offset_level_en, bias_level_en};
	always #20 clk_sys = ~clk_sys;
	mrd_top dut_u (.*);
	mrd_ctrl_model pm_u (.clk_sys(clk_sys), .sclk(serial_port_clock),
		.sel_n(serial_port_select_n), .din(serial_port_data_in),
		.dout(serial_port_data_out));
	////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic tally_and_finish();
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic settle();
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic bus_w(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys) bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys) bus_wr <= 1'b0;
	endtask
	task automatic bus_r(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk_sys) bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk_sys) bus_rd <= 1'b0;
	endtask
	task automatic cmd(input logic [7:0] v);
		@(posedge clk_sys);
		{driver_level_sel, driver_mode_sel, driver_block_sel} <= v;
		@(posedge clk_sys) driver_strobe <= 1'b1;
		tick(10);
		driver_strobe <= 1'b0;
		tick(10);
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge clk_sys) rd_seen <= bus_rd;
	always @(negedge clk_sys) begin
		if (rd_seen) begin
			cmp(bus_rdata, exp_q.pop_front());
		end
	end
	initial begin
		#400000;
		bad_count++;
		tally_and_finish();
	end
	////////////////////////////////
	initial begin
		tick(5);
		rst_b <= 1'b1;
		bus_r(mrd_pkg::OFF_CTRL, 32'h0);
		bus_r(mrd_pkg::OFF_MASK, 32'h0);
		settle();
		cmp({driver_interrupt_n, drv_enable, ens}, 5'h10);
		cmp(drv_offset_force, 1'b1);
		r = lfsr(r);
		cmd(r);
		settle();
		cmp({drv_level, drv_mode, drv_block}, {2'h0, r[5:0]});
		@(posedge clk_sys) driver_initialise_n <= 1'b1;
		tick(10);
		settle();
		cmp({drv_offset_force, drv_level}, {1'b0, r[7:6]});
		repeat (4) begin
			r = lfsr(r);
			cmd(r);
			settle();
			cmp({drv_level, drv_mode, drv_block}, r);
			bus_r(mrd_pkg::OFF_LATCH, {24'h0, r});
		end
		bus_r(mrd_pkg::OFF_CCNT, 32'h5);
		@(posedge clk_sys) driver_output_enable_n <= 1'b0;
		tick(10);
		settle();
		cmp(drv_enable, 1'b1);
		bus_r(mrd_pkg::OFF_PINS, 32'h6);
		@(posedge clk_sys) driver_output_enable_n <= 1'b1;
		tick(10);
		settle();
		cmp(drv_enable, 1'b0);
		// strobe captures and enable toggles both left their marks
		bus_r(mrd_pkg::OFF_STAT, 32'h11);
		bus_w(mrd_pkg::OFF_STAT, 32'h1f);
		bus_r(mrd_pkg::OFF_STAT, 32'h0);
		bus_w(mrd_pkg::OFF_MASK, 32'h1);
		r = lfsr(r);
		lat = r;
		cmd(r);
		settle();
		cmp(driver_interrupt_n, 1'b0);
		bus_w(mrd_pkg::OFF_MASK, 32'h0);
		settle();
		cmp(driver_interrupt_n, 1'b1);
		bus_r(mrd_pkg::OFF_STAT, 32'h1);
		bus_w(mrd_pkg::OFF_MASK, 32'h1);
		bus_w(mrd_pkg::OFF_STAT, 32'h1);
		settle();
		cmp(driver_interrupt_n, 1'b1);
		bus_w(mrd_pkg::OFF_CTRL, 32'h7);
		settle();
		cmp(ens, 3'h7);
		r = lfsr(r);
		pm_u.frame(8'h00, r, 16, 1'b1, rb);
		settle();
		cmp(ens, r[2:0]);
		bus_r(mrd_pkg::OFF_SDATA, {24'h0, r});
		bus_r(mrd_pkg::OFF_STAT, 32'h4);
		pm_u.frame(8'h00, ~r, 16, 1'b0, rb);
		settle();
		cmp(ens, r[2:0]);
		// reserved bit set: the write must be dropped whole
		pm_u.frame(8'h40, ~r, 16, 1'b1, rb);
		settle();
		cmp(ens, r[2:0]);
		bus_r(mrd_pkg::OFF_SDATA, {24'h0, r});
		pm_u.frame(8'h00, ~r, 4, 1'b1, rb);
		bus_r(mrd_pkg::OFF_STAT, 32'hc);
		pm_u.frame(8'h81, 8'h00, 16, 1'b1, rb);
		cmp(rb, lat);
		// initialise asserted again mid-run forces the offset level
		@(posedge clk_sys) driver_initialise_n <= 1'b0;
		tick(10);
		settle();
		cmp({drv_offset_force, drv_level}, 3'h4);
		bus_r(mrd_pkg::OFF_STAT, 32'he);
		bus_r(8'h40, 32'h0);
		settle();
		tally_and_finish();
	end
endmodule
`default_nettype wire
